// [design/mspm_pkg.sv]
// Package: constants, modes and carrier types for the memory/serial/pulse pin mux
package mspm_pkg;

  // ----------------------------------------------------------------
  // Serial-flash pin positions, shared with port C bit numbers
  // ----------------------------------------------------------------
  localparam int unsigned FP_CLK = 0;
  localparam int unsigned FP_OUT = 1;
  localparam int unsigned FP_IN = 2;
  localparam int unsigned FP_SEL0 = 3;
  localparam int unsigned FP_SEL1 = 4;
  localparam int unsigned GPC_PULSE = 7;
  localparam int unsigned FLASH_PINS = 5;

  // ----------------------------------------------------------------
  // Strap codes and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] CHIP_STRAP_ISP = 2'h1;
  localparam logic CMD_IDLE_N = 1'h1;
  localparam logic SEL1_PULL_RST = 1'h1;
  localparam logic PULSE_PULLDOWN_RST = 1'h1;
  localparam logic [4:0] FLASH_OE_RST = 5'h00;
  localparam int unsigned SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // Second pulse pin function select
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MSPM_P2_PWM = 2'b00,
    MSPM_P2_OSC = 2'b01,
    MSPM_P2_ERR = 2'b10
  } mspm_p2_sel_t;

  // Memory command, each bit high when asserted
  typedef struct packed {
    logic select;
    logic row_strobe;
    logic col_strobe;
    logic write_enable;
  } mspm_mem_cmd_t;

  // Serial master engine outputs
  typedef struct packed {
    logic serial_master_clock;
    logic serial_master_out;
    logic flash_select0_n;
    logic flash_select1_n;
    logic [1:0] dual_out;
    logic [1:0] dual_oe;
  } mspm_spi_t;

endpackage

// [design/mspm_sync.sv]
// Three-stage pin synchroniser with second/third stage agreement filter
module mspm_sync
  import mspm_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] ff1;
  logic [W-1:0] ff2;
  logic [W-1:0] ff3;
  logic [W-1:0] next_dout;

  // ----------------------------------------------------------------
  // Accept a bit once the last two stages agree
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < W; i++) begin
      next_dout[i] = (ff2[i] == ff3[i]) ? ff3[i] : dout[i];
    end
    if (SYS_RST) begin
      next_dout = ff3;
    end
  end

  // Stage registers; first stage feeds only the second
  always_ff @(posedge CLK) begin
    ff1 <= din;
    ff2 <= ff1;
    ff3 <= ff2;
    dout <= next_dout;
  end

endmodule

// [design/mspm_pin_mux.sv]
// Pin function mux for memory, serial-flash and pulse-width pin groups
// Overview of operation
// - Clock strap bit zero low drives the clock-enable pin, high turns it into a clock input.
// - The memory clock pin follows the memory PLL or the external memory clock per the strap.
// - Memory commands appear active low on select, row, column and write-enable outputs.
// - With the serial master off, flash pins become port C bits 0 to 4, inputs by default.
// - During reset flash select 1 is pulled up unless the chip straps read 01.
// - Single-bit mode drives master-out and samples master-in.
// - Dual-bit mode turns both data pins bidirectional, only during flash DMA.
// - The first pulse pin has a pull-down only while reset is active.
// - With pulse output off the first pulse pin is port C bit 7 or the core clock divided by two.
// - Strap bit zero low drives the second pulse pin with pulse, oscillator or error flag.
// - Strap bit zero high makes the second pulse pin the panel scan clock input.
// - Strap bit zero selects internal PLL clocks at 0 and the external clock inputs at 1.
// - Chip straps of 01 float all serial master pins for an external programmer.
module mspm_pin_mux
  import mspm_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CLK_TEST_STRAP,
  input wire logic [1:0] CHIP_TEST_STRAP,
  input wire mspm_mem_cmd_t MEM_CMD,
  input wire logic MEM_CLK_ENABLE,
  input wire logic MEMORY_PLL,
  input wire logic SPI_ENABLE,
  input wire logic SPI_DUAL,
  input wire logic SPI_DMA_ACTIVE,
  input wire mspm_spi_t SPI_ENGINE,
  input wire logic [7:0] GPIO_C_OUT,
  input wire logic [7:0] GPIO_C_DIR,
  input wire logic PWM_ENABLE,
  input wire logic PULSE_FIRST_CORE_CLK,
  input wire logic PULSE_FIRST_LEVEL,
  input wire mspm_p2_sel_t PULSE_SECOND_SEL,
  input wire logic PULSE_SECOND_LEVEL,
  input wire logic OSC_CLK_LEVEL,
  input wire logic SCAN_BW_ERR,
  input wire logic MEM_RANGE_ERR,
  input wire logic MEM_CLK_ENABLE_PIN_I,
  output logic MEM_CLK_ENABLE_PIN_O,
  output logic MEM_CLK_ENABLE_PIN_OE,
  output logic MEMORY_CLOCK_OUT,
  output logic MEM_SELECT_N,
  output logic MEM_ROW_STROBE_N,
  output logic MEM_COL_STROBE_N,
  output logic MEM_WRITE_ENABLE_N,
  input wire logic [4:0] FLASH_PIN_I,
  output logic [4:0] FLASH_PIN_O,
  output logic [4:0] FLASH_PIN_OE,
  output logic FLASH_SELECT1_PULLUP,
  input wire logic PULSE_OUT_FIRST_I,
  output logic PULSE_OUT_FIRST_O,
  output logic PULSE_OUT_FIRST_OE,
  output logic PULSE_FIRST_PULLDOWN,
  input wire logic PULSE_OUT_SECOND_I,
  output logic PULSE_OUT_SECOND_O,
  output logic PULSE_OUT_SECOND_OE,
  output logic [7:0] GPIO_C_IN,
  output logic SPI_MISO_IN,
  output logic [1:0] SPI_DUAL_IN,
  output logic EXT_MEMORY_CLOCK,
  output logic EXT_PANEL_SCAN_CLOCK,
  output logic CLK_BYPASS,
  output logic FLASH_ISP,
  output logic INIT_DISPLAY_EN
);

  // ----------------------------------------------------------------
  // Pin input synchronisation
  // ----------------------------------------------------------------
  logic [10:0] pins_raw, pins_sync;
  logic strap_clk_s, ext_mem_s, pulse1_s, pulse2_s;
  logic [1:0] strap_chip_s;
  logic [4:0] flash_s;

  assign pins_raw = {CLK_TEST_STRAP, CHIP_TEST_STRAP, MEM_CLK_ENABLE_PIN_I, FLASH_PIN_I,
                     PULSE_OUT_FIRST_I, PULSE_OUT_SECOND_I};
  assign {strap_clk_s, strap_chip_s, ext_mem_s, flash_s, pulse1_s, pulse2_s} = pins_sync;

  mspm_sync #(.W(11)) u_sync (
    .CLK(CLK),
    .SYS_RST(SYS_RST),
    .din(pins_raw),
    .dout(pins_sync)
  );

  // ----------------------------------------------------------------
  // Straps and registered pin controls
  // ----------------------------------------------------------------
  logic clk_strap, next_clk_strap;
  logic chip_isp, next_chip_isp;
  logic init_disp, next_init_disp;
  logic core_div, next_core_div;
  logic cke_o, next_cke_o, cke_oe, next_cke_oe;
  logic mclk, next_mclk;
  logic [3:0] cmd_n, next_cmd_n;
  logic [4:0] fl_o, next_fl_o, fl_oe, next_fl_oe;
  logic sel1_pu, next_sel1_pu;
  logic p1_o, next_p1_o, p1_oe, next_p1_oe, p1_pd, next_p1_pd;
  logic p2_o, next_p2_o, p2_oe, next_p2_oe;
  logic [7:0] gin, next_gin;
  logic miso, next_miso;
  logic [1:0] dual_in, next_dual_in;
  logic ext_mclk, next_ext_mclk, ext_scan, next_ext_scan;
  logic isp, dual_live;

  assign isp = next_chip_isp;
  assign dual_live = SPI_DUAL && SPI_DMA_ACTIVE;

  // Straps follow the pins while reset is held, then freeze
  always_comb begin
    next_clk_strap = SYS_RST ? strap_clk_s : clk_strap;
    next_chip_isp = SYS_RST ? (strap_chip_s == CHIP_STRAP_ISP) : chip_isp;
    next_init_disp = SYS_RST ? pulse1_s : init_disp;
    next_core_div = SYS_RST ? 1'b0 : ~core_div;
  end

  // Memory group: clock enable, clock source and command strobes
  always_comb begin
    next_cke_o = SYS_RST ? 1'b0 : MEM_CLK_ENABLE;
    next_cke_oe = !SYS_RST && !next_clk_strap;
    next_mclk = next_clk_strap ? ext_mem_s : MEMORY_PLL;
    next_ext_mclk = next_clk_strap && ext_mem_s;
    next_cmd_n = SYS_RST ? {4{CMD_IDLE_N}} : ~MEM_CMD;
  end

  // Serial-flash group: master, dual data, port C or floating
  always_comb begin
    next_fl_o = 5'h00;
    next_fl_oe = FLASH_OE_RST;
    next_sel1_pu = SYS_RST ? (isp ? 1'b0 : SEL1_PULL_RST) : 1'b0;
    if (SYS_RST || isp) begin
      next_fl_oe = FLASH_OE_RST;
    end else if (!SPI_ENABLE) begin
      next_fl_o = GPIO_C_OUT[4:0];
      next_fl_oe = GPIO_C_DIR[4:0];
    end else begin
      next_fl_o[FP_CLK] = SPI_ENGINE.serial_master_clock;
      next_fl_o[FP_SEL0] = SPI_ENGINE.flash_select0_n;
      next_fl_o[FP_SEL1] = SPI_ENGINE.flash_select1_n;
      next_fl_oe[FP_CLK] = 1'b1;
      next_fl_oe[FP_SEL0] = 1'b1;
      next_fl_oe[FP_SEL1] = 1'b1;
      if (dual_live) begin
        next_fl_o[FP_OUT] = SPI_ENGINE.dual_out[0];
        next_fl_o[FP_IN] = SPI_ENGINE.dual_out[1];
        next_fl_oe[FP_OUT] = SPI_ENGINE.dual_oe[0];
        next_fl_oe[FP_IN] = SPI_ENGINE.dual_oe[1];
      end else begin
        next_fl_o[FP_OUT] = SPI_ENGINE.serial_master_out;
        next_fl_oe[FP_OUT] = 1'b1;
        next_fl_oe[FP_IN] = 1'b0;
      end
    end
    next_gin = {pulse1_s, 2'b00, flash_s};
    next_miso = flash_s[FP_IN];
    next_dual_in = {flash_s[FP_IN], flash_s[FP_OUT]};
  end

  // Pulse group: first pin function and reset pull-down
  always_comb begin
    next_p1_pd = SYS_RST ? PULSE_PULLDOWN_RST : 1'b0;
    next_p1_o = 1'b0;
    next_p1_oe = 1'b0;
    if (!SYS_RST) begin
      if (PWM_ENABLE) begin
        next_p1_o = PULSE_FIRST_LEVEL;
        next_p1_oe = 1'b1;
      end else if (PULSE_FIRST_CORE_CLK) begin
        next_p1_o = core_div;
        next_p1_oe = 1'b1;
      end else begin
        next_p1_o = GPIO_C_OUT[GPC_PULSE];
        next_p1_oe = GPIO_C_DIR[GPC_PULSE];
      end
    end
  end

  // Pulse group: second pin output select or scan clock input
  always_comb begin
    unique case (PULSE_SECOND_SEL)
      MSPM_P2_PWM: next_p2_o = PULSE_SECOND_LEVEL;
      MSPM_P2_OSC: next_p2_o = OSC_CLK_LEVEL;
      MSPM_P2_ERR: next_p2_o = SCAN_BW_ERR || MEM_RANGE_ERR;
      default: next_p2_o = 1'b0;
    endcase
    next_p2_oe = !SYS_RST && !next_clk_strap;
    next_ext_scan = next_clk_strap && pulse2_s;
  end

  // Registers for every group
  always_ff @(posedge CLK) begin
    clk_strap <= next_clk_strap;
    chip_isp <= next_chip_isp;
    init_disp <= next_init_disp;
    core_div <= next_core_div;
    cke_o <= next_cke_o;
    cke_oe <= next_cke_oe;
    mclk <= next_mclk;
    ext_mclk <= next_ext_mclk;
    cmd_n <= next_cmd_n;
    fl_o <= next_fl_o;
    fl_oe <= next_fl_oe;
    sel1_pu <= next_sel1_pu;
    gin <= next_gin;
    miso <= next_miso;
    dual_in <= next_dual_in;
    p1_o <= next_p1_o;
    p1_oe <= next_p1_oe;
    p1_pd <= next_p1_pd;
    p2_o <= next_p2_o;
    p2_oe <= next_p2_oe;
    ext_scan <= next_ext_scan;
  end

  // Port outputs straight from the registers
  assign MEM_CLK_ENABLE_PIN_O = cke_o;
  assign MEM_CLK_ENABLE_PIN_OE = cke_oe;
  assign MEMORY_CLOCK_OUT = mclk;
  assign {MEM_SELECT_N, MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N} = cmd_n;
  assign FLASH_PIN_O = fl_o;
  assign FLASH_PIN_OE = fl_oe;
  assign FLASH_SELECT1_PULLUP = sel1_pu;
  assign PULSE_OUT_FIRST_O = p1_o;
  assign PULSE_OUT_FIRST_OE = p1_oe;
  assign PULSE_FIRST_PULLDOWN = p1_pd;
  assign PULSE_OUT_SECOND_O = p2_o;
  assign PULSE_OUT_SECOND_OE = p2_oe;
  assign GPIO_C_IN = gin;
  assign SPI_MISO_IN = miso;
  assign SPI_DUAL_IN = dual_in;
  assign EXT_MEMORY_CLOCK = ext_mclk;
  assign EXT_PANEL_SCAN_CLOCK = ext_scan;
  assign CLK_BYPASS = clk_strap;
  assign FLASH_ISP = chip_isp;
  assign INIT_DISPLAY_EN = init_disp;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_reset_release;
    SYS_RST ##1 !SYS_RST;
  endsequence
  sequence s_running;
    !SYS_RST [*2];
  endsequence
  property p_cke_dir;
    @(posedge CLK) s_running |-> (MEM_CLK_ENABLE_PIN_OE == !CLK_BYPASS);
  endproperty
  a_cke_dir: assert property (p_cke_dir) else $error("clock-enable drive wrong");
  property p_mclk_src;
    @(posedge CLK) disable iff (SYS_RST)
      !SYS_RST ##1 !SYS_RST |->
        MEMORY_CLOCK_OUT == (clk_strap ? $past(ext_mem_s) : $past(MEMORY_PLL));
  endproperty
  a_mclk_src: assert property (p_mclk_src) else $error("memory clock source wrong");
  property p_cmd;
    @(posedge CLK) disable iff (SYS_RST)
      !SYS_RST |=> ({MEM_SELECT_N, MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N}
                    == ~$past(MEM_CMD));
  endproperty
  a_cmd: assert property (p_cmd) else $error("memory command not inverted");
  property p_gpio;
    @(posedge CLK) disable iff (SYS_RST)
      (!SPI_ENABLE && !isp) |=> FLASH_PIN_OE == $past(GPIO_C_DIR[4:0]);
  endproperty
  a_gpio: assert property (p_gpio) else $error("port C direction not applied");
  // Synchroniser needs several reset cycles before the chip straps are known
  property p_sel1_pull;
    @(posedge CLK) SYS_RST [*6] |=> FLASH_SELECT1_PULLUP == !$past(isp);
  endproperty
  a_sel1_pull: assert property (p_sel1_pull) else $error("select 1 pull-up wrong");
  property p_single;
    @(posedge CLK) disable iff (SYS_RST)
      (SPI_ENABLE && !dual_live && !isp) |=> FLASH_PIN_OE[1] && !FLASH_PIN_OE[2];
  endproperty
  a_single: assert property (p_single) else $error("single mode directions wrong");
  property p_dual;
    @(posedge CLK) disable iff (SYS_RST)
      (SPI_ENABLE && !isp && SPI_DUAL && !SPI_DMA_ACTIVE) |=> FLASH_PIN_OE[1] && !FLASH_PIN_OE[2];
  endproperty
  a_dual: assert property (p_dual) else $error("dual mode outside DMA");
  property p_pulldown;
    @(posedge CLK) s_reset_release |=> !PULSE_FIRST_PULLDOWN && $past(PULSE_FIRST_PULLDOWN);
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pull-down not released");
  property p_p2_float;
    @(posedge CLK) disable iff (SYS_RST) CLK_BYPASS |-> !PULSE_OUT_SECOND_OE;
  endproperty
  a_p2_float: assert property (p_p2_float) else $error("scan clock pin driven");
  property p_isp;
    @(posedge CLK) FLASH_ISP |=> FLASH_PIN_OE == 5'h00;
  endproperty
  a_isp: assert property (p_isp) else $error("flash pins driven in ISP mode");

endmodule

// [dv/mspm_board.sv]
// Board model: flash, clock sources and initial display strap on the far side of the pins
module mspm_board (
  input wire logic clk,
  input wire logic mce_o,
  input wire logic mce_oe,
  input wire logic mclk_src,
  output logic mce_i,
  input wire logic [4:0] fl_o,
  input wire logic [4:0] fl_oe,
  input wire logic fl_pu,
  input wire logic [4:0] fl_en,
  input wire logic [4:0] fl_drv,
  output logic [4:0] fl_i,
  input wire logic p1_o,
  input wire logic p1_oe,
  input wire logic p1_pd,
  input wire logic init_want,
  output logic p1_i,
  input wire logic p2_o,
  input wire logic p2_oe,
  input wire logic scan_src,
  output logic p2_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] fl_q = 5'h00;
  logic p1_q = 1'h0;

  // Released lines show the inverse of their last level
  always_ff @(posedge clk) begin
    fl_q <= ~fl_i;
    p1_q <= ~p1_i;
  end

  // Clock sources drive whenever the device leaves the pin
  assign mce_i = mce_oe ? mce_o : mclk_src;
  assign p2_i = p2_oe ? p2_o : scan_src;

  // Flash lines: device first, then flash chip, then select-1 pull-up
  always_comb begin
    for (int b = 0; b < 5; b++) begin
      if (fl_oe[b]) fl_i[b] = fl_o[b];
      else if (fl_en[b]) fl_i[b] = fl_drv[b];
      else if (b == 4 && fl_pu) fl_i[b] = 1'h1;
      else fl_i[b] = fl_q[b];
    end
  end

  // Board pull-up asks for the initial display, else the pull-down holds it low
  always_comb begin
    if (p1_oe) p1_i = p1_o;
    else if (init_want) p1_i = 1'h1;
    else if (p1_pd) p1_i = 1'h0;
    else p1_i = p1_q;
  end
endmodule

// [dv/tb.sv]
// Testbench: pin function checks for the memory/serial/pulse pin mux
module tb import mspm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'h0;
  logic SYS_RST, CLK_TEST_STRAP, MEM_CLK_ENABLE, MEMORY_PLL, SPI_ENABLE, SPI_DUAL;
  logic SPI_DMA_ACTIVE, PWM_ENABLE, PULSE_FIRST_CORE_CLK, PULSE_FIRST_LEVEL;
  logic PULSE_SECOND_LEVEL, OSC_CLK_LEVEL, SCAN_BW_ERR, MEM_RANGE_ERR, SPI_MISO_IN;
  logic MEM_CLK_ENABLE_PIN_I, MEM_CLK_ENABLE_PIN_O, MEM_CLK_ENABLE_PIN_OE, MEMORY_CLOCK_OUT;
  logic MEM_SELECT_N, MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N;
  logic FLASH_SELECT1_PULLUP, PULSE_OUT_FIRST_I, PULSE_OUT_FIRST_O, PULSE_OUT_FIRST_OE;
  logic PULSE_FIRST_PULLDOWN, PULSE_OUT_SECOND_I, PULSE_OUT_SECOND_O, PULSE_OUT_SECOND_OE;
  logic EXT_MEMORY_CLOCK, EXT_PANEL_SCAN_CLOCK, CLK_BYPASS, FLASH_ISP, INIT_DISPLAY_EN;
  logic [1:0] CHIP_TEST_STRAP, SPI_DUAL_IN;
  logic [7:0] GPIO_C_OUT, GPIO_C_DIR, GPIO_C_IN;
  logic [4:0] FLASH_PIN_I, FLASH_PIN_O, FLASH_PIN_OE, fl_en, fl_drv;
  logic [3:0] cmd_n;
  logic mclk_src, scan_src, init_want, lvl;
  mspm_mem_cmd_t MEM_CMD;
  mspm_spi_t SPI_ENGINE;
  mspm_p2_sel_t PULSE_SECOND_SEL;
  int mismatches = 0;
  int n_tests = 0;

  assign cmd_n = {MEM_SELECT_N, MEM_ROW_STROBE_N, MEM_COL_STROBE_N, MEM_WRITE_ENABLE_N};

  // Core clock at 40 MHz
  always #12.5 CLK = ~CLK;

  mspm_pin_mux DUT (.CLK, .SYS_RST, .CLK_TEST_STRAP, .CHIP_TEST_STRAP, .MEM_CMD,
    .MEM_CLK_ENABLE, .MEMORY_PLL, .SPI_ENABLE, .SPI_DUAL, .SPI_DMA_ACTIVE, .SPI_ENGINE,
    .GPIO_C_OUT, .GPIO_C_DIR, .PWM_ENABLE, .PULSE_FIRST_CORE_CLK, .PULSE_FIRST_LEVEL,
    .PULSE_SECOND_SEL, .PULSE_SECOND_LEVEL, .OSC_CLK_LEVEL, .SCAN_BW_ERR, .MEM_RANGE_ERR,
    .MEM_CLK_ENABLE_PIN_I, .MEM_CLK_ENABLE_PIN_O, .MEM_CLK_ENABLE_PIN_OE, .MEMORY_CLOCK_OUT,
    .MEM_SELECT_N, .MEM_ROW_STROBE_N, .MEM_COL_STROBE_N, .MEM_WRITE_ENABLE_N, .FLASH_PIN_I,
    .FLASH_PIN_O, .FLASH_PIN_OE, .FLASH_SELECT1_PULLUP, .PULSE_OUT_FIRST_I, .PULSE_OUT_FIRST_O,
    .PULSE_OUT_FIRST_OE, .PULSE_FIRST_PULLDOWN, .PULSE_OUT_SECOND_I, .PULSE_OUT_SECOND_O,
    .PULSE_OUT_SECOND_OE, .GPIO_C_IN, .SPI_MISO_IN, .SPI_DUAL_IN, .EXT_MEMORY_CLOCK,
    .EXT_PANEL_SCAN_CLOCK, .CLK_BYPASS, .FLASH_ISP, .INIT_DISPLAY_EN);

  mspm_board board (.clk(CLK), .mce_o(MEM_CLK_ENABLE_PIN_O), .mce_oe(MEM_CLK_ENABLE_PIN_OE),
    .mclk_src(mclk_src), .mce_i(MEM_CLK_ENABLE_PIN_I), .fl_o(FLASH_PIN_O),
    .fl_oe(FLASH_PIN_OE), .fl_pu(FLASH_SELECT1_PULLUP), .fl_en(fl_en), .fl_drv(fl_drv),
    .fl_i(FLASH_PIN_I), .p1_o(PULSE_OUT_FIRST_O), .p1_oe(PULSE_OUT_FIRST_OE),
    .p1_pd(PULSE_FIRST_PULLDOWN), .init_want(init_want), .p1_i(PULSE_OUT_FIRST_I),
    .p2_o(PULSE_OUT_SECOND_O), .p2_oe(PULSE_OUT_SECOND_OE), .scan_src(scan_src),
    .p2_i(PULSE_OUT_SECOND_I));

  // Compare one value and count it
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Single-bit compare
  task automatic chb(input string name, input logic exp, input logic got);
    chk(name, {7'h00, exp}, {7'h00, got});
  endtask

  // Wait on falling edges, where inputs change and outputs are settled
  task automatic tick(input int n);
    repeat (n) @(negedge CLK);
  endtask

  // Verdict and end of run
  task automatic summarize();
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Reset with given straps, checking reset-time pins and latched straps
  task automatic do_reset(input logic cs, input logic [1:0] ts, input logic want);
    SYS_RST = 1'h1;
    CLK_TEST_STRAP = cs;
    CHIP_TEST_STRAP = ts;
    init_want = want;
    tick(12);
    chb("pullup", ts != CHIP_STRAP_ISP, FLASH_SELECT1_PULLUP);
    chb("pulldown", 1'h1, PULSE_FIRST_PULLDOWN);
    chk("rst_oe", 8'h00, {FLASH_PIN_OE, MEM_CLK_ENABLE_PIN_OE, PULSE_OUT_FIRST_OE,
      PULSE_OUT_SECOND_OE});
    chk("rst_cmd", 8'h0f, 8'(cmd_n));
    SYS_RST = 1'h0;
    tick(6);
    chb("pulldown", 1'h0, PULSE_FIRST_PULLDOWN);
    chk("straps", 8'({cs, ts == CHIP_STRAP_ISP, want}),
      8'({CLK_BYPASS, FLASH_ISP, INIT_DISPLAY_EN}));
  endtask

  // One serial master setting: mode bits, lines the flash drives, expected drivers
  task automatic spi_case(input logic [1:0] md, input logic [4:0] en, oe, o);
    {SPI_DUAL, SPI_DMA_ACTIVE} = md;
    fl_en = en;
    fl_drv = en;
    tick(6);
    chk("spi_oe", 8'(oe), 8'(FLASH_PIN_OE));
    chk("spi_o", 8'(o), 8'(FLASH_PIN_O & FLASH_PIN_OE));
  endtask

  // Main sequence
  initial begin
    {MEM_CLK_ENABLE, MEMORY_PLL, SPI_DUAL, SPI_DMA_ACTIVE, PWM_ENABLE} = '0;
    {PULSE_FIRST_CORE_CLK, PULSE_FIRST_LEVEL, PULSE_SECOND_LEVEL, OSC_CLK_LEVEL} = '0;
    {SCAN_BW_ERR, MEM_RANGE_ERR, mclk_src, scan_src, fl_en, fl_drv, SPI_ENGINE} = '0;
    PULSE_SECOND_SEL = MSPM_P2_PWM;
    MEM_CMD = 4'hf;
    SPI_ENABLE = 1'h1;
    GPIO_C_OUT = 8'h9f;
    GPIO_C_DIR = 8'hff;
    do_reset(1'h0, 2'h0, 1'h1);
    for (int c = 0; c < 16; c++) begin
      MEM_CMD = mspm_mem_cmd_t'(c[3:0]);
      {MEMORY_PLL, MEM_CLK_ENABLE} = c[1:0];
      tick(1);
      chk("cmd_n", {4'h0, ~c[3:0]}, 8'(cmd_n));
      chk("cke", 8'({1'h1, c[0], c[1], 1'h0}), 8'({MEM_CLK_ENABLE_PIN_OE,
        MEM_CLK_ENABLE_PIN_O, MEMORY_CLOCK_OUT, EXT_MEMORY_CLOCK}));
    end
    SPI_ENABLE = 1'h0;
    fl_drv = 5'h13;
    for (int d = 0; d < 3; d++) begin
      GPIO_C_DIR = 8'(d * 10);
      fl_en = ~GPIO_C_DIR[4:0];
      tick(6);
      chk("gpio_oe", GPIO_C_DIR, 8'(FLASH_PIN_OE));
      chk("gpio_in", 8'(GPIO_C_DIR[4:0] | (fl_en & fl_drv)), 8'(GPIO_C_IN[4:0]));
    end
    SPI_ENABLE = 1'h1;
    SPI_ENGINE = 8'haa;
    spi_case(2'h0, 5'h04, 5'h1b, 5'h09);
    chb("miso", 1'h1, SPI_MISO_IN);
    spi_case(2'h2, 5'h04, 5'h1b, 5'h09);
    spi_case(2'h3, 5'h02, 5'h1d, 5'h0d);
    chk("dual_in", 8'h03, 8'(SPI_DUAL_IN));
    PWM_ENABLE = 1'h1;
    PULSE_FIRST_LEVEL = 1'h1;
    tick(2);
    chk("p1_pwm", 8'h03, 8'({PULSE_OUT_FIRST_OE, PULSE_OUT_FIRST_O}));
    PWM_ENABLE = 1'h0;
    tick(6);
    chk("p1_gpi", 8'h01, 8'({PULSE_OUT_FIRST_OE, GPIO_C_IN[7]}));
    GPIO_C_DIR = 8'h80;
    GPIO_C_OUT = 8'h1f;
    tick(2);
    chk("p1_gpo", 8'h02, 8'({PULSE_OUT_FIRST_OE, PULSE_OUT_FIRST_O}));
    PULSE_FIRST_CORE_CLK = 1'h1;
    tick(2);
    lvl = PULSE_OUT_FIRST_O;
    tick(1);
    chb("p1_clk", ~lvl, PULSE_OUT_FIRST_O);
    for (int k = 0; k < 6; k++) begin
      PULSE_SECOND_SEL = mspm_p2_sel_t'(k % 3);
      {PULSE_SECOND_LEVEL, OSC_CLK_LEVEL, SCAN_BW_ERR, MEM_RANGE_ERR} = k < 3 ? 4'ha : 4'h5;
      tick(2);
      chk("p2", 8'({1'h1, (k % 3 == 2) || ((k < 3) ^ (k % 3 == 1))}),
        8'({PULSE_OUT_SECOND_OE, PULSE_OUT_SECOND_O}));
    end
    fl_en = 5'h00;
    do_reset(1'h1, 2'h1, 1'h0);
    chk("isp_oe", 8'h00, 8'({FLASH_PIN_OE, MEM_CLK_ENABLE_PIN_OE,
      PULSE_OUT_SECOND_OE}));
    for (int v = 1; v >= 0; v--) begin
      {mclk_src, scan_src} = {2{v[0]}};
      tick(6);
      chk("ext_clk", 8'({3{v[0]}}), 8'({EXT_MEMORY_CLOCK, MEMORY_CLOCK_OUT,
        EXT_PANEL_SCAN_CLOCK}));
    end
    summarize();
  end
endmodule
